// [verilog/apsio_top.sv]
// Four-axis pulse output and sensor input logic with an AXI4-Lite slave.
// Assumes one 100 MHz clock, synchronous active-low reset, pins from outside.
//
// How it works
// [RULE_01] At constant speed each drive pulse has equal high and low halves.
// [RULE_02] In pulse-plus-direction mode the positive output carries all pulses.
// [RULE_03] In pulse-plus-direction mode the negative output is a direction level.
// [RULE_04] Both pulse outputs are low in reset and pulse only while driving.
// [RULE_05] In encoder mode the two phases are decoded into up and down counts.
// [RULE_06] In up/down mode a rising up input increments the real position.
// [RULE_07] In up/down mode a rising down input decrements the real position.
// [RULE_08] With settle input enabled, busy stays set until it is active.
// [RULE_09] Software enables and sets the active level of settle and alarm inputs.
// [RULE_10] An enabled, active alarm input sets the alarm flag in status two.
// [RULE_11] An active plus limit stops plus driving, decelerating or sudden.
// [RULE_12] An active minus limit stops minus driving, decelerating or sudden.
// [RULE_13] Without a filter a limit input must stay active two clocks.
// [RULE_14] An enabled, active plus limit sets the plus limit flag.
// [RULE_15] An enabled, active minus limit sets the minus limit flag.
// [RULE_16] Reset must be held low over four clocks with the clock running.
// [RULE_17] Four independent copies exist, one per axis.
`timescale 1ns/1ns
`include "apsio_defs.svh"

module apsio_top (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address.
	input wire logic [`APSIO_ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// AXI4-Lite write data.
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response.
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read address.
	input wire logic [`APSIO_ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	// AXI4-Lite read data.
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Drive pulse outputs, one bit per axis.
	output logic [`APSIO_NAXIS-1:0] pos_pulse_out,
	output logic [`APSIO_NAXIS-1:0] neg_pulse_or_direction_out,
	// Encoder or up/down pulse inputs.
	input wire logic [`APSIO_NAXIS-1:0] phase_a_or_up_in,
	input wire logic [`APSIO_NAXIS-1:0] phase_b_or_down_in,
	// Servo and limit inputs.
	input wire logic [`APSIO_NAXIS-1:0] servo_settled_in,
	input wire logic [`APSIO_NAXIS-1:0] servo_alarm_in,
	input wire logic [`APSIO_NAXIS-1:0] plus_overtravel_in,
	input wire logic [`APSIO_NAXIS-1:0] minus_overtravel_in
);

	localparam int NPIN = 6 * `APSIO_NAXIS;

	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_sync;
	logic [`APSIO_NAXIS-1:0] a_s;
	logic [`APSIO_NAXIS-1:0] b_s;
	logic [`APSIO_NAXIS-1:0] settled_s;
	logic [`APSIO_NAXIS-1:0] alarm_s;
	logic [`APSIO_NAXIS-1:0] plim_s;
	logic [`APSIO_NAXIS-1:0] mlim_s;

	logic [5:0] ctrl_reg [`APSIO_NAXIS];
	logic [15:0] speed_reg [`APSIO_NAXIS];
	logic [31:0] pulses_reg [`APSIO_NAXIS];
	logic [7:0] sense_reg [`APSIO_NAXIS];
	logic [31:0] real_pos_reg [`APSIO_NAXIS];
	logic [2:0] secondary_status_register [`APSIO_NAXIS];
	logic [`APSIO_NAXIS-1:0] start_reg;
	logic [`APSIO_NAXIS-1:0] stop_reg;
	logic [`APSIO_NAXIS-1:0] a_prev_reg;
	logic [`APSIO_NAXIS-1:0] b_prev_reg;
	logic [`APSIO_NAXIS-1:0] busy;
	logic [`APSIO_NAXIS-1:0] cnt_up;
	logic [`APSIO_NAXIS-1:0] cnt_down;

	logic aw_have_reg;
	logic w_have_reg;
	logic [`APSIO_ADDR_W-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic wr_fire;
	logic wr_ok;
	logic [1:0] wr_axis;
	logic [2:0] wr_idx;
	logic aw_have_next;
	logic w_have_next;
	logic rd_fire;
	logic [31:0] rd_word;
	logic rd_ok;
	logic [1:0] rd_axis;
	logic [2:0] rd_idx;

	function automatic logic [31:0] apsio_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return res;
	endfunction

	// Pin inputs cross into the clock domain.
	assign pin_raw = {minus_overtravel_in, plus_overtravel_in, servo_alarm_in, servo_settled_in,
		phase_b_or_down_in, phase_a_or_up_in};
	assign {mlim_s, plim_s, alarm_s, settled_s, b_s, a_s} = pin_sync;

	for (genvar g = 0; g < NPIN; g++) begin : g_sync
		apsio_sync u_sync (
			.aclk(aclk),
			.aresetn(aresetn),
			.pin_in(pin_raw[g]),
			.level_out(pin_sync[g])
		);
	end

	// Per-axis pulse generators, each fully independent.
	for (genvar x = 0; x < `APSIO_NAXIS; x++) begin : g_axis // [RULE_17]
		apsio_axis u_axis (
			.aclk(aclk),
			.aresetn(aresetn),
			.start(start_reg[x]),
			.stop_req(stop_reg[x]),
			.dir_minus(ctrl_reg[x][`APSIO_CTRL_DIR]),
			.pdir_mode(ctrl_reg[x][`APSIO_CTRL_PDIR]),
			.sudden_mode(ctrl_reg[x][`APSIO_CTRL_SUDDEN]),
			.half_period(speed_reg[x]),
			.pulse_total(pulses_reg[x]),
			.plus_lim_act(secondary_status_register[x][`APSIO_ST2_PLIM]), // [RULE_13]
			.minus_lim_act(secondary_status_register[x][`APSIO_ST2_MLIM]), // [RULE_13]
			.settle_wait(sense_reg[x][`APSIO_SENSE_SERVO_SETTLED_IN_EN]), // [RULE_09]
			.settle_ok(settled_s[x] == sense_reg[x][`APSIO_SENSE_SERVO_SETTLED_IN_LVL]), // [RULE_08]
			.pos_pulse_out(pos_pulse_out[x]),
			.neg_pulse_or_direction_out(neg_pulse_or_direction_out[x]),
			.axis_busy_bit(busy[x])
		);
	end

	// Count events from encoder phases or from up/down pulses.
	always_comb begin
		for (int x = 0; x < `APSIO_NAXIS; x++) begin
			if (ctrl_reg[x][`APSIO_CTRL_UPDN]) begin
				cnt_up[x] = a_s[x] && !a_prev_reg[x]; // [RULE_06]
				cnt_down[x] = b_s[x] && !b_prev_reg[x]; // [RULE_07]
			end else begin
				cnt_up[x] = ((a_s[x] ^ a_prev_reg[x]) ^ (b_s[x] ^ b_prev_reg[x]))
					&& !(a_prev_reg[x] ^ b_s[x]); // [RULE_05]
				cnt_down[x] = ((a_s[x] ^ a_prev_reg[x]) ^ (b_s[x] ^ b_prev_reg[x]))
					&& (a_prev_reg[x] ^ b_s[x]); // [RULE_05]
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			a_prev_reg <= '0;
			b_prev_reg <= '0;
		end else begin
			a_prev_reg <= a_s;
			b_prev_reg <= b_s;
		end
	end

	// Real position counters; a software load wins over a count.
	always_ff @(posedge aclk) begin
		for (int x = 0; x < `APSIO_NAXIS; x++) begin
			if (!aresetn) begin
				real_pos_reg[x] <= 32'h0000_0000;
			end else if (wr_fire && wr_ok && wr_axis == x[1:0] && wr_idx == `APSIO_IDX_REALPOS) begin
				real_pos_reg[x] <= apsio_merge(real_pos_reg[x], w_data_reg, w_strb_reg);
			end else if (cnt_up[x] && !cnt_down[x]) begin
				real_pos_reg[x] <= real_pos_reg[x] + 32'h0000_0001; // [RULE_05] [RULE_06]
			end else if (cnt_down[x] && !cnt_up[x]) begin
				real_pos_reg[x] <= real_pos_reg[x] - 32'h0000_0001; // [RULE_05] [RULE_07]
			end
		end
	end

	// Status flags follow the enabled inputs at their active level.
	always_ff @(posedge aclk) begin
		for (int x = 0; x < `APSIO_NAXIS; x++) begin
			if (!aresetn) begin
				secondary_status_register[x] <= 3'h0;
			end else begin
				secondary_status_register[x][`APSIO_ST2_ALARM] <=
					sense_reg[x][`APSIO_SENSE_ALARM_EN] &&
					(alarm_s[x] == sense_reg[x][`APSIO_SENSE_ALARM_LVL]); // [RULE_09] [RULE_10]
				secondary_status_register[x][`APSIO_ST2_PLIM] <=
					sense_reg[x][`APSIO_SENSE_PLIM_EN] &&
					(plim_s[x] == sense_reg[x][`APSIO_SENSE_PLIM_LVL]); // [RULE_14]
				secondary_status_register[x][`APSIO_ST2_MLIM] <=
					sense_reg[x][`APSIO_SENSE_MLIM_EN] &&
					(mlim_s[x] == sense_reg[x][`APSIO_SENSE_MLIM_LVL]); // [RULE_15]
			end
		end
	end

	// Write channel: address and data are taken in either order.
	assign wr_fire = aw_have_reg && w_have_reg && !bvalid;
	assign wr_axis = aw_addr_reg[`APSIO_AXIS_HI:`APSIO_AXIS_LO];
	assign wr_idx = aw_addr_reg[`APSIO_IDX_HI:`APSIO_IDX_LO];
	assign wr_ok = !aw_addr_reg[`APSIO_ADDR_HI] && (wr_idx == `APSIO_IDX_CTRL ||
		wr_idx == `APSIO_IDX_SPEED || wr_idx == `APSIO_IDX_PULSES ||
		wr_idx == `APSIO_IDX_SENSE || wr_idx == `APSIO_IDX_REALPOS);
	assign aw_have_next = aw_have_reg ? !wr_fire : (awvalid && awready);
	assign w_have_next = w_have_reg ? !wr_fire : (wvalid && wready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else begin
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			awready <= !aw_have_next;
			wready <= !w_have_next;
			if (awvalid && awready) begin
				aw_addr_reg <= awaddr;
			end
			if (wvalid && wready) begin
				w_data_reg <= wdata;
				w_strb_reg <= wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= `APSIO_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp <= wr_ok ? `APSIO_RESP_OKAY : `APSIO_RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Software registers and command pulses.
	always_ff @(posedge aclk) begin
		for (int x = 0; x < `APSIO_NAXIS; x++) begin
			if (!aresetn) begin
				ctrl_reg[x] <= `APSIO_CTRL_RST;
				speed_reg[x] <= `APSIO_SPEED_RST;
				pulses_reg[x] <= `APSIO_PULSES_RST;
				sense_reg[x] <= `APSIO_SENSE_RST;
				start_reg[x] <= 1'b0;
				stop_reg[x] <= 1'b0;
			end else begin
				start_reg[x] <= 1'b0;
				stop_reg[x] <= 1'b0;
				if (wr_fire && wr_ok && wr_axis == x[1:0]) begin
					unique case (wr_idx)
						`APSIO_IDX_CTRL: begin
							if (w_strb_reg[0]) begin
								ctrl_reg[x] <= w_data_reg[5:0];
								start_reg[x] <= w_data_reg[`APSIO_CTRL_START];
								stop_reg[x] <= w_data_reg[`APSIO_CTRL_STOP];
							end
						end
						`APSIO_IDX_SPEED: begin
							speed_reg[x] <= 16'(apsio_merge({16'h0000, speed_reg[x]}, w_data_reg,
								w_strb_reg));
						end
						`APSIO_IDX_PULSES: begin
							pulses_reg[x] <= apsio_merge(pulses_reg[x], w_data_reg, w_strb_reg);
						end
						`APSIO_IDX_SENSE: begin
							if (w_strb_reg[0]) begin
								sense_reg[x] <= w_data_reg[7:0]; // [RULE_09]
							end
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	// Read channel: one cycle from address to data.
	assign rd_fire = arvalid && arready;
	assign rd_axis = araddr[`APSIO_AXIS_HI:`APSIO_AXIS_LO];
	assign rd_idx = araddr[`APSIO_IDX_HI:`APSIO_IDX_LO];

	always_comb begin
		rd_ok = !araddr[`APSIO_ADDR_HI];
		rd_word = 32'h0000_0000;
		unique case (rd_idx)
			`APSIO_IDX_CTRL: rd_word = {26'h000_0000, ctrl_reg[rd_axis][5:2], 2'h0};
			`APSIO_IDX_SPEED: rd_word = {16'h0000, speed_reg[rd_axis]};
			`APSIO_IDX_PULSES: rd_word = pulses_reg[rd_axis];
			`APSIO_IDX_SENSE: rd_word = {24'h00_0000, sense_reg[rd_axis]};
			`APSIO_IDX_STATUS: rd_word = {31'h0000_0000, busy[rd_axis]}; // [RULE_08]
			`APSIO_IDX_STATUS2: rd_word = {29'h0000_0000, secondary_status_register[rd_axis]};
			`APSIO_IDX_REALPOS: rd_word = real_pos_reg[rd_axis];
			default: rd_ok = 1'b0;
		endcase
		if (!rd_ok) begin
			rd_word = 32'h0000_0000;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `APSIO_RESP_OKAY;
		end else if (rd_fire) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= rd_ok ? `APSIO_RESP_OKAY : `APSIO_RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end else begin
			arready <= !rvalid;
		end
	end

endmodule // apsio_top

// [verilog/apsio_defs.svh]
// Constants of the four-axis pulse and sensor I/O block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef APSIO_DEFS_SVH
`define APSIO_DEFS_SVH

`define APSIO_NAXIS 4
`define APSIO_ADDR_W 8
`define APSIO_ADDR_HI 7
`define APSIO_AXIS_HI 6
`define APSIO_AXIS_LO 5
`define APSIO_IDX_HI 4
`define APSIO_IDX_LO 2

`define APSIO_IDX_CTRL 3'h0
`define APSIO_IDX_SPEED 3'h1
`define APSIO_IDX_PULSES 3'h2
`define APSIO_IDX_SENSE 3'h3
`define APSIO_IDX_STATUS 3'h4
`define APSIO_IDX_STATUS2 3'h5
`define APSIO_IDX_REALPOS 3'h6

`define APSIO_CTRL_START 0
`define APSIO_CTRL_STOP 1
`define APSIO_CTRL_DIR 2
`define APSIO_CTRL_PDIR 3
`define APSIO_CTRL_UPDN 4
`define APSIO_CTRL_SUDDEN 5
`define APSIO_CTRL_RST 6'h00

`define APSIO_SENSE_SERVO_SETTLED_IN_EN 0
`define APSIO_SENSE_SERVO_SETTLED_IN_LVL 1
`define APSIO_SENSE_ALARM_EN 2
`define APSIO_SENSE_ALARM_LVL 3
`define APSIO_SENSE_PLIM_EN 4
`define APSIO_SENSE_PLIM_LVL 5
`define APSIO_SENSE_MLIM_EN 6
`define APSIO_SENSE_MLIM_LVL 7
`define APSIO_SENSE_RST 8'h00

`define APSIO_ST2_ALARM 0
`define APSIO_ST2_PLIM 1
`define APSIO_ST2_MLIM 2

`define APSIO_SPEED_RST 16'h0064
`define APSIO_PULSES_RST 32'h0000_0000
`define APSIO_DECEL_PULSES 3'h4

`define APSIO_RESP_OKAY 2'h0
`define APSIO_RESP_SLVERR 2'h2

`endif

// [verilog/apsio_pkg.sv]
// Types shared by the pulse and sensor I/O block.
// Assumes nothing of its surroundings.
package apsio_pkg;

	typedef enum logic [1:0] {
		APSIO_IDLE,
		APSIO_RUN,
		APSIO_DECEL,
		APSIO_SETTLE
	} apsio_state_type;

endpackage

// [verilog/apsio_sync.sv]
// Three-stage synchroniser for one pin input.
// Assumes an asynchronous input and the single system clock.
`timescale 1ns/1ns

module apsio_sync (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Pin side.
	input wire logic pin_in,
	// Synchronised level.
	output logic level_out
);

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// The level changes only once the second and third stages agree.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_out <= 1'b0;
		end else if (s2_reg == s3_reg) begin
			level_out <= s3_reg;
		end
	end

endmodule // apsio_sync

// [verilog/apsio_axis.sv]
// Drive pulse generator of one axis.
// Assumes synchronised, level-qualified limit and settle inputs.
`timescale 1ns/1ns
`include "apsio_defs.svh"

module apsio_axis (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Commands.
	input wire logic start,
	input wire logic stop_req,
	input wire logic dir_minus,
	input wire logic pdir_mode,
	input wire logic sudden_mode,
	input wire logic [15:0] half_period,
	input wire logic [31:0] pulse_total,
	// Sensors.
	input wire logic plus_lim_act,
	input wire logic minus_lim_act,
	input wire logic settle_wait,
	input wire logic settle_ok,
	// Outputs.
	output logic pos_pulse_out,
	output logic neg_pulse_or_direction_out,
	output logic axis_busy_bit
);

	apsio_pkg::apsio_state_type state_reg;
	apsio_pkg::apsio_state_type state_next;
	logic [16:0] cnt_reg;
	logic [16:0] period;
	logic phase_reg;
	logic [31:0] left_reg;
	logic cont_reg;
	logic dir_reg;
	logic [2:0] decel_reg;
	logic stop_pend_reg;
	logic stop_sudden_reg;
	logic tick;
	logic pulse_end;
	logic last_pulse;
	logic lim_hit;
	logic moving;

	assign moving = (state_reg == apsio_pkg::APSIO_RUN) || (state_reg == apsio_pkg::APSIO_DECEL);
	assign period = (state_reg == apsio_pkg::APSIO_DECEL) ? {half_period, 1'b0} : {1'b0, half_period};
	assign tick = (period == 17'h0_0000) || (cnt_reg >= period - 17'h0_0001);
	assign pulse_end = moving && tick && phase_reg;
	assign last_pulse = !cont_reg && (left_reg == 32'h0000_0001);
	assign lim_hit = moving && (dir_reg ? minus_lim_act : plus_lim_act); // [RULE_11] [RULE_12]

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			apsio_pkg::APSIO_IDLE: begin
				if (start) begin
					state_next = apsio_pkg::APSIO_RUN;
				end
			end
			apsio_pkg::APSIO_RUN: begin
				if (pulse_end && (last_pulse || (stop_pend_reg && stop_sudden_reg))) begin
					state_next = settle_wait ? apsio_pkg::APSIO_SETTLE : apsio_pkg::APSIO_IDLE;
				end else if (pulse_end && stop_pend_reg) begin
					state_next = apsio_pkg::APSIO_DECEL; // [RULE_11] [RULE_12]
				end
			end
			apsio_pkg::APSIO_DECEL: begin
				if (pulse_end && (last_pulse || decel_reg == 3'h0 || stop_sudden_reg)) begin
					state_next = settle_wait ? apsio_pkg::APSIO_SETTLE : apsio_pkg::APSIO_IDLE;
				end
			end
			apsio_pkg::APSIO_SETTLE: begin
				if (!settle_wait || settle_ok) begin
					state_next = apsio_pkg::APSIO_IDLE; // [RULE_08]
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= apsio_pkg::APSIO_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Half-period timer and pulse phase; equal high and low halves.
	always_ff @(posedge aclk) begin
		if (!aresetn || !moving) begin
			cnt_reg <= 17'h0_0000;
			phase_reg <= 1'b0;
		end else if (tick) begin
			cnt_reg <= 17'h0_0000;
			phase_reg <= !phase_reg; // [RULE_01]
		end else begin
			cnt_reg <= cnt_reg + 17'h0_0001;
		end
	end

	// Job parameters latched at start, pulse count and deceleration tail.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			left_reg <= `APSIO_PULSES_RST;
			cont_reg <= 1'b0;
			dir_reg <= 1'b0;
			decel_reg <= 3'h0;
		end else if (state_reg == apsio_pkg::APSIO_IDLE && start) begin
			left_reg <= pulse_total;
			cont_reg <= (pulse_total == 32'h0000_0000);
			dir_reg <= dir_minus;
			decel_reg <= `APSIO_DECEL_PULSES - 3'h1;
		end else if (pulse_end) begin
			left_reg <= left_reg - 32'h0000_0001;
			if (state_reg == apsio_pkg::APSIO_DECEL && decel_reg != 3'h0) begin
				decel_reg <= decel_reg - 3'h1;
			end
		end
	end

	// Pending stop from a limit or from software; only a limit stop takes its kind from sudden_mode.
	always_ff @(posedge aclk) begin
		if (!aresetn || state_reg == apsio_pkg::APSIO_IDLE) begin
			stop_pend_reg <= 1'b0;
			stop_sudden_reg <= 1'b0;
		end else if (lim_hit) begin
			stop_pend_reg <= 1'b1; // [RULE_11] [RULE_12]
			stop_sudden_reg <= stop_sudden_reg | sudden_mode;
		end else if (moving && stop_req) begin
			stop_pend_reg <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pos_pulse_out <= 1'b0; // [RULE_04]
			neg_pulse_or_direction_out <= 1'b0; // [RULE_04]
			axis_busy_bit <= 1'b0;
		end else begin
			pos_pulse_out <= phase_reg && (pdir_mode || !dir_reg); // [RULE_02]
			neg_pulse_or_direction_out <= pdir_mode ? dir_reg : (phase_reg && dir_reg); // [RULE_03]
			axis_busy_bit <= (state_next != apsio_pkg::APSIO_IDLE); // [RULE_08]
		end
	end

endmodule // apsio_axis

// [verif/apsio_top_assertions.sv]
// Port checks of the four-axis pulse and sensor I/O top.
// Assumes the bind below attaches it to every apsio_top.
`timescale 1ns/1ns
`include "apsio_defs.svh"

module apsio_top_chk (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Write channels.
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	// Read channels.
	input wire logic [`APSIO_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	// Pulse outputs.
	input wire logic [`APSIO_NAXIS-1:0] pos_pulse_out,
	input wire logic [`APSIO_NAXIS-1:0] neg_pulse_or_direction_out
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		awvalid && awready && wvalid && wready && !bvalid;
	endsequence
	sequence wr_answered;
		##[1:2] bvalid;
	endsequence
	reset_quiet_a:
	assert property ($rose(aresetn) |-> !pos_pulse_out && !neg_pulse_or_direction_out)
		else $error("pulse outputs not low in reset");
	write_answer_a:
	assert property (wr_taken |-> wr_answered) else $error("write response late");
	bresp_hold_a:
	assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp dropped");
	rdata_hold_a:
	assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read data dropped");
	read_answer_a:
	assert property (arvalid && arready |=> rvalid) else $error("read answer late");
	read_block_a:
	assert property (rvalid |-> !arready) else $error("read taken while busy");
	addr_hold_a:
	assert property (awvalid && awready |=> !awready) else $error("second address taken");
	unmapped_read_a:
	assert property (arvalid && arready && araddr[4:2] == 3'h7 |=> rresp == 2'h2 && rdata == 32'h0)
		else $error("unmapped read answered");
endmodule // apsio_top_chk

bind apsio_top apsio_top_chk chk_u (.*);

// [verif/apsio_motor_model.sv]
// Motor driver with encoder and in-position output for one axis.
// Assumes the bench tells it the pulse form and the encoder form.
`timescale 1ns/1ns

module apsio_motor_model (
	// Clock.
	input wire logic aclk,
	// Forms chosen by the bench.
	input wire logic pdir_mode,
	input wire logic updn_mode,
	// Drive pins.
	input wire logic pulse_plus,
	input wire logic pulse_minus,
	// Encoder and in-position pins.
	output logic enc_a,
	output logic enc_b,
	output logic settled
);
	logic [1:0] step_reg = 2'h0;
	logic up_q = 1'b0;
	logic dn_q = 1'b0;
	int quiet = 0;
	logic up;
	logic dn;
	assign up = pdir_mode ? (pulse_plus && !pulse_minus) : pulse_plus;
	assign dn = pdir_mode ? (pulse_plus && pulse_minus) : pulse_minus;
	always_ff @(posedge aclk) begin
		up_q <= up;
		dn_q <= dn;
		if (up && !up_q)
			step_reg <= step_reg + 2'h1;
		else if (dn && !dn_q)
			step_reg <= step_reg - 2'h1;
		quiet <= (up || dn) ? 0 : quiet + 1;
	end
	// Phase A leads for plus travel; echoed pulses in up/down form.
	assign enc_a = updn_mode ? up : (step_reg[0] ^ step_reg[1]);
	assign enc_b = updn_mode ? dn : step_reg[1];
	assign settled = quiet > 40;
endmodule // apsio_motor_model

// [verif/tb_top.sv]
// Bench of the four-axis pulse and sensor I/O block.
// Assumes the design, checker and motor model are compiled first.
`timescale 1ns/1ns

module tb_top;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pdir, updn;
	logic awready, wready, bvalid, arready, rvalid, pq, nq;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rv;
	logic [1:0] bresp, rresp, rs;
	logic [3:0] pos_o, neg_o, ea, eb, settled, alarm, plim, mlim;
	int miscompares = 0, compares = 0, cycles = 0, ax = 0, npos = 0, nneg = 0;
	int run = 0, hi_w = 0, lo_w = 0;

	apsio_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .pos_pulse_out(pos_o),
		.neg_pulse_or_direction_out(neg_o), .phase_a_or_up_in(ea), .phase_b_or_down_in(eb),
		.servo_settled_in(settled), .servo_alarm_in(alarm), .plus_overtravel_in(plim),
		.minus_overtravel_in(mlim));
	for (genvar i = 0; i < 4; i++) begin : g_motor
		apsio_motor_model motor_u (.aclk(aclk), .pdir_mode(pdir), .updn_mode(updn),
			.pulse_plus(pos_o[i]), .pulse_minus(neg_o[i]), .enc_a(ea[i]), .enc_b(eb[i]),
			.settled(settled[i]));
	end

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic end_sim;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (compares > 0 && miscompares == 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// Cycle limit; running out counts as a mismatch.
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			miscompares++;
			end_sim;
		end
	end

	// Pulse counts and the last high and low widths of the watched axis.
	always @(posedge aclk) begin
		pq <= pos_o[ax];
		nq <= neg_o[ax];
		run <= (pos_o[ax] != pq) ? 1 : run + 1;
		if (pos_o[ax] && !pq) begin
			npos <= npos + 1;
			lo_w <= run;
		end
		if (!pos_o[ax] && pq)
			hi_w <= run;
		if (neg_o[ax] && !nq)
			nneg <= nneg + 1;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid && !bready)
				bready <= 1'b1;
		end while (!(bvalid && bready));
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic rdv(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && !rready)
				rready <= 1'b1;
		end while (!(rvalid && rready));
		rready <= 1'b0;
		rv = rdata;
		rs = rresp;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		rdv(a);
		chk(rv, e);
		chk({30'h0, rs}, {30'h0, er});
	endtask

	task automatic go(input logic [7:0] b, input logic [31:0] sp, input logic [31:0] n,
		input logic [5:0] c);
		pdir <= c[3];
		updn <= c[4];
		wr(b + 8'h04, sp, 2'h0);
		wr(b + 8'h08, n, 2'h0);
		wr(b + 8'h18, 32'h0, 2'h0);
		npos = 0;
		nneg = 0;
		wr(b, {26'h0, c}, 2'h0);
		repeat (2) @(posedge aclk);
	endtask

	task automatic done(input logic [7:0] b);
		do
			rdv(b + 8'h10);
		while (rv[0] !== 1'b0);
		repeat (8) @(posedge aclk);
	endtask

	initial begin
		logic [5:0] c;
		logic [7:0] b;
		logic [5:0] cases [6];
		cases = '{6'h11, 6'h15, 6'h05, 6'h01, 6'h19, 6'h1d};
		{aresetn, awvalid, wvalid, bready, arvalid, rready, pdir, updn} <= 8'h00;
		{awaddr, araddr, wdata} <= 48'h0;
		{alarm, plim, mlim} <= 12'h000;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(8'h04, 32'h64, 2'h0);
		rd(8'h0c, 32'h0, 2'h0);
		rd(8'h10, 32'h0, 2'h0);
		rd(8'h1c, 32'h0, 2'h2);
		rd(8'h80, 32'h0, 2'h2);
		wr(8'h10, 32'h1, 2'h2);
		$display("test registers done");
		for (int a = 0; a < 4; a++) begin
			ax = a;
			b = 8'(a * 32);
			for (int k = 0; k < 6; k++) begin
				c = cases[k];
				go(b, 32'h3, 32'h2, c);
				done(b);
				chk(npos, (c[3] || !c[2]) ? 2 : 0);
				chk(nneg, c[3] ? {31'h0, c[2]} : (c[2] ? 2 : 0));
				chk({31'h0, neg_o[a]}, {31'h0, c[3] & c[2]});
				if (c[3] || !c[2]) begin
					chk(hi_w, 3);
					chk(lo_w, 3);
				end
				rd(b + 8'h18, c[2] ? 32'hffff_fffe : 32'h2, 2'h0);
			end
		end
		$display("test drive done");
		ax = 0;
		wr(8'h0c, 32'h03, 2'h0);
		go(8'h00, 32'h3, 32'h2, 6'h11);
		wait (npos == 2);
		repeat (16) @(posedge aclk);
		rd(8'h10, 32'h1, 2'h0);
		repeat (60) @(posedge aclk);
		rd(8'h10, 32'h0, 2'h0);
		$display("test settle done");
		alarm[0] <= 1'b1;
		wr(8'h0c, 32'h0c, 2'h0);
		repeat (8) @(posedge aclk);
		rd(8'h14, 32'h1, 2'h0);
		wr(8'h0c, 32'h04, 2'h0);
		repeat (8) @(posedge aclk);
		rd(8'h14, 32'h0, 2'h0);
		wr(8'h0c, 32'h08, 2'h0);
		repeat (8) @(posedge aclk);
		rd(8'h14, 32'h0, 2'h0);
		alarm[0] <= 1'b0;
		$display("test alarm done");
		for (int m = 0; m < 4; m++) begin
			wr(8'h0c, m[0] ? 32'hc0 : 32'h30, 2'h0);
			go(8'h00, 32'ha, 32'h0, {m[1], 2'h0, m[0], 1'b0, 1'b1});
			wait ((m[0] ? nneg : npos) == 3);
			if (m[0])
				mlim[0] <= 1'b1;
			else
				plim[0] <= 1'b1;
			done(8'h00);
			chk(m[0] ? nneg : npos, m[1] ? 3 : 7);
			rd(8'h14, m[0] ? 32'h4 : 32'h2, 2'h0);
			plim[0] <= 1'b0;
			mlim[0] <= 1'b0;
		end
		$display("test limits done");
		go(8'h00, 32'ha, 32'h0, 6'h01);
		wait (npos == 2);
		wr(8'h00, 32'h2, 2'h0);
		done(8'h00);
		chk(npos, 6);
		$display("test stop done");
		end_sim;
	end
endmodule // tb_top
